// File: design/adc_config_result_regs.sv
// Behaviour
// - Result register is zero after reset until a conversion finishes.
// - Each finished conversion's two's complement word lands in the result.
// - Start bit begins one conversion only when powered down and idle.
// - Start bit always reads back as zero.
// - Input-select field picks one of eight input pairings, reset 000.
// - Gain-range field picks full scale, reset 010, top codes alike.
// - Mode bit 0 converts continuously, 1 powers down for single shots.
// - Rate-select doubles from 64 SPS to 8 kSPS, reset code 100.
// - Temperature-sense bit switches converter to internal sensor.
// - Pull-up bit enables weak pull-up on data pin while select high.
// - Received word updates the register only with qualifier 01.
// - Bit 8 ignores writes and reads one.
// - Bits 4:0 ignore writes and read zero.
// - Rate-boost 01 forces 16 kSPS, 10 or 11 force 32 kSPS.
// - Chop bit enables global chopping, reset one.
// - Configuration register resets to 058b20.
// - Long frames echo the first word's written setting in second half.
// - Result bit 23 leaves on first rising edge; input sampled falling.
module adc_config_result_regs
  import adc_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic conv_done,
  input wire logic [23:0] conv_data,
  output logic data_out_ready_n,
  output logic data_out_ready_n_oe,
  output logic pullup_on,
  output logic conv_start,
  output cfg_s conv_cfg,
  output logic [15:0] conv_rate_sps
);

  // Link side outputs
  logic link_started;
  logic link_so;
  logic [23:0] link_rx_word;
  logic link_rx_tgl;

  // Synchronised copies in the system domain
  logic [3:0] sync_v;
  logic cs_s;
  logic started_s;
  logic so_s;
  logic tgl_s;

  // Pin and edge group
  logic cs_prev_q, cs_prev_d;
  logic tgl_prev_q, tgl_prev_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;
  logic pull_q, pull_d;

  // Core group
  conv_state_e state_q, state_d;
  cfg_s config_q, config_d;
  logic [23:0] result_q, result_d;
  logic [23:0] snap_res_q, snap_res_d;
  logic [23:0] snap_cfg_q, snap_cfg_d;
  logic ready_n_q, ready_n_d;
  logic busy_q, busy_d;
  logic start_q, start_d;
  logic [15:0] rate_q, rate_d;

  // Decoded events
  logic frame_start;
  logic rx_evt;
  logic cfg_write;
  logic ss_req;
  logic done_ok;
  cfg_s rx_cfg;

  // Link logic on the serial clock; snapshots are quasi-static per frame
  serial_link u_link (
    .sclk(sclk),
    .nrst(nrst),
    .cs_n(cs_n),
    .sdi(sdi),
    .tx_result(snap_res_q),
    .tx_cfg(snap_cfg_q),
    .started(link_started),
    .so_bit(link_so),
    .rx_word(link_rx_word),
    .rx_toggle(link_rx_tgl)
  );

  // Select idles high so reset never fakes a frame start
  sync2 #(
    .W(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .clk(clk_sys),
    .nrst(nrst),
    .async_in({cs_n, link_started, link_so, link_rx_tgl}),
    .sync_out(sync_v)
  );

  assign cs_s = sync_v[3];
  assign started_s = sync_v[2];
  assign so_s = sync_v[1];
  assign tgl_s = sync_v[0];

  // Events seen after the synchronisers only
  assign frame_start = cs_prev_q & ~cs_s;
  assign rx_evt = tgl_s ^ tgl_prev_q;
  assign rx_cfg = cfg_s'(link_rx_word);
  assign cfg_write = rx_evt & qual_ok(link_rx_word);
  assign done_ok = conv_done & busy_q;
  // Start only counts while powered down and nothing is running
  assign ss_req = cfg_write & rx_cfg.single_shot &
                  (state_q == ST_PDOWN) & ~busy_q;

  // Pin drive: ready level before the first edge, then shifted bits.
  // The resync costs about three system clocks, well inside half an
  // sclk period at the link rates this part is meant for.
  always_comb begin
    cs_prev_d = cs_s;
    tgl_prev_d = tgl_s;
    pin_d = started_s ? so_s : ready_n_q;
    oe_d = ~cs_s;
    pull_d = cs_s & config_q.output_pullup_enable;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cs_prev_q <= 1'b1;
      tgl_prev_q <= 1'b0;
      pin_q <= 1'b1;
      oe_q <= 1'b0;
      pull_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_prev_d;
      tgl_prev_q <= tgl_prev_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      pull_q <= pull_d;
    end
  end

  // Sequencer, register updates and frame snapshots
  always_comb begin
    state_d = state_q;
    config_d = config_q;
    result_d = result_q;
    snap_res_d = snap_res_q;
    snap_cfg_d = snap_cfg_q;
    ready_n_d = ready_n_q;
    busy_d = busy_q;
    start_d = 1'b0;
    rate_d = rate_sps(config_q);
    // Frozen at frame start so a late conversion cannot tear a read
    if (frame_start) begin
      snap_res_d = result_q;
      snap_cfg_d = cfg_read_view(config_q);
      ready_n_d = 1'b1;
    end
    // Completion wins over the read that clears the ready flag
    if (done_ok) begin
      result_d = conv_data;
      ready_n_d = 1'b0;
      busy_d = 1'b0;
    end
    if (cfg_write) begin
      config_d = cfg_s'(cfg_read_view(link_rx_word));
    end
    case (state_q)
      ST_PDOWN: begin
        if (ss_req) begin
          state_d = ST_SINGLE;
          start_d = 1'b1;
          busy_d = 1'b1;
        end else if (!config_q.mode_pdown) begin
          state_d = ST_CONT;
        end
      end
      ST_SINGLE: begin
        if (done_ok) begin
          state_d = ST_PDOWN;
        end
      end
      ST_CONT: begin
        // Mode change waits for the running conversion to end
        if (config_q.mode_pdown && !busy_q) begin
          state_d = ST_PDOWN;
        end else if (!busy_q) begin
          start_d = 1'b1;
          busy_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_PDOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_PDOWN;
      config_q <= cfg_s'(CFG_RESET);
      result_q <= RESULT_RESET;
      snap_res_q <= RESULT_RESET;
      snap_cfg_q <= CFG_RESET;
      ready_n_q <= 1'b1;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      // Same figure the reset setting decodes to, so no false rate shows
      rate_q <= rate_sps(cfg_s'(CFG_RESET));
    end else begin
      state_q <= state_d;
      config_q <= config_d;
      result_q <= result_d;
      snap_res_q <= snap_res_d;
      snap_cfg_q <= snap_cfg_d;
      ready_n_q <= ready_n_d;
      busy_q <= busy_d;
      start_q <= start_d;
      rate_q <= rate_d;
    end
  end

  // Converter controls and pin drive straight from registers
  assign conv_cfg = config_q;
  assign conv_rate_sps = rate_q;
  assign conv_start = start_q;
  assign data_out_ready_n = pin_q;
  assign data_out_ready_n_oe = oe_q;
  assign pullup_on = pull_q;

  // Checks on the system clock
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  result_hold_a: assert property (
    !done_ok |=> $stable(result_q))
    else $error("result changed without a finished conversion");

  result_load_a: assert property (
    done_ok |=> result_q == $past(conv_data) && !ready_n_q)
    else $error("finished conversion not captured");

  ss_start_a: assert property (
    ss_req |=> conv_start && state_q == ST_SINGLE ##1 !conv_start)
    else $error("single shot start not a one cycle pulse");

  ss_busy_a: assert property (
    state_q == ST_SINGLE |=> !conv_start)
    else $error("start issued during a running single shot");

  ss_read_a: assert property (
    !config_q.single_shot && !snap_cfg_q[23])
    else $error("start bit reads back as one");

  rsv_bits_a: assert property (
    config_q.rsv_one && config_q.rsv_zero == 5'h00 && snap_cfg_q[8])
    else $error("reserved bits hold wrong values");

  qual_block_a: assert property (
    rx_evt && !qual_ok(link_rx_word) |=> $stable(config_q))
    else $error("unqualified word changed the register");

  qual_write_a: assert property (
    cfg_write |=> config_q == cfg_s'(cfg_read_view($past(link_rx_word))))
    else $error("qualified word not stored");

  pullup_a: assert property (
    ##1 pullup_on == $past(cs_s & config_q.output_pullup_enable))
    else $error("pull-up does not follow select and enable");

  cont_run_a: assert property (
    state_q == ST_CONT && !config_q.mode_pdown && !busy_q |=> conv_start)
    else $error("continuous mode failed to restart");

  single_end_a: assert property (
    state_q == ST_SINGLE && done_ok |=> state_q == ST_PDOWN)
    else $error("single shot did not power down");

  rate_follow_a: assert property (
    ##1 conv_rate_sps == rate_sps($past(config_q)))
    else $error("data rate does not track the setting");

  pull_drive_a: assert property (
    !(pullup_on && data_out_ready_n_oe))
    else $error("pull-up applied while the pin is driven");

  start_src_a: assert property (
    conv_start |-> $past(ss_req) || $past(state_q) == ST_CONT)
    else $error("conversion started outside a legal request");

  pdown_idle_a: assert property (
    state_q == ST_PDOWN && config_q.mode_pdown && !ss_req |=> !conv_start)
    else $error("powered-down converter started on its own");

  single_cycle_c: cover property (
    ss_req ##[1:1000] state_q == ST_PDOWN);
  cont_run_c: cover property (
    state_q == ST_CONT && conv_start);
  write_frame_c: cover property (
    frame_start ##[1:1000] cfg_write);
  ss_refused_c: cover property (
    cfg_write && rx_cfg.single_shot && busy_q);
  cont_stop_c: cover property (
    state_q == ST_CONT ##1 state_q == ST_PDOWN);

endmodule // adc_config_result_regs

// File: design/adc_regs_pkg.sv
package adc_regs_pkg;

  // Word width of both registers
  localparam int WORD_W = 24;

  // Reset values of the two registers
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [23:0] CFG_RESET = 24'h058b20;

  // Read-back view: start bit and low reserved bits read 0, bit 8 reads 1
  localparam logic [23:0] CFG_RD_CLEAR = 24'h80001f;
  localparam logic [23:0] CFG_RD_SET = 24'h000100;

  // Write qualifier code that lets a received word update the register
  localparam logic [1:0] QUAL_VALID = 2'h1;

  // Serial frame lengths in clock edges
  localparam logic [5:0] HALF_BITS = 6'h18;
  localparam logic [5:0] LONG_BITS = 6'h30;

  // Data rate figures in samples per second
  localparam logic [15:0] RATE_BASE_SPS = 16'h0040;
  localparam logic [15:0] RATE_BOOST1_SPS = 16'h3e80;
  localparam logic [15:0] RATE_BOOST2_SPS = 16'h7d00;

  // Field layout of the configuration register, bit 23 first
  typedef struct packed {
    logic single_shot;
    logic [2:0] input_select;
    logic [2:0] gain_range_select;
    logic mode_pdown;
    logic [2:0] rate_select;
    logic temp_sense_select;
    logic output_pullup_enable;
    logic [1:0] write_qualifier;
    logic rsv_one;
    logic [1:0] rate_boost;
    logic chop_enable;
    logic [4:0] rsv_zero;
  } cfg_s;

  // Converter sequencing states
  typedef enum logic [2:0] {
    ST_PDOWN = 3'b001,
    ST_SINGLE = 3'b010,
    ST_CONT = 3'b100
  } conv_state_e;

  // Value that software sees for a stored or received word
  function automatic logic [23:0] cfg_read_view(input logic [23:0] w);
    cfg_read_view = (w & ~CFG_RD_CLEAR) | CFG_RD_SET;
  endfunction

  // A received word only counts with the valid qualifier code
  function automatic logic qual_ok(input logic [23:0] w);
    cfg_s c;
    c = cfg_s'(w);
    qual_ok = (c.write_qualifier == QUAL_VALID);
  endfunction

  // Effective output data rate, boost overrides the select field
  function automatic logic [15:0] rate_sps(input cfg_s c);
    case (c.rate_boost)
      2'h0: rate_sps = RATE_BASE_SPS << c.rate_select;
      2'h1: rate_sps = RATE_BOOST1_SPS;
      default: rate_sps = RATE_BOOST2_SPS;
    endcase
  endfunction

endpackage

// File: design/serial_link.sv
module serial_link
  import adc_regs_pkg::*;
(
  input wire logic sclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [23:0] tx_result,
  input wire logic [23:0] tx_cfg,
  output logic started,
  output logic so_bit,
  output logic [23:0] rx_word,
  output logic rx_toggle
);

  // Frame state dies with chip select; sclk stands still outside frames
  logic frame_rst_n;
  assign frame_rst_n = nrst & ~cs_n;

  logic [5:0] tx_cnt_q, tx_cnt_d;
  logic [23:0] tx_sh_q, tx_sh_d;
  logic so_q, so_d;
  logic started_q;
  logic [5:0] rx_cnt_q, rx_cnt_d;
  logic [22:0] rx_sh_q, rx_sh_d;
  logic [23:0] rx_word_q, rx_word_d;
  logic rx_tgl_q, rx_tgl_d;
  logic [23:0] readback;

  // Second half echoes this frame's qualified write, else the snapshot
  assign readback = (rx_cnt_q >= HALF_BITS && qual_ok(rx_word_q)) ?
                    cfg_read_view(rx_word_q) : tx_cfg;

  // Rising edges shift out: result first, then the read-back word
  always_comb begin
    tx_cnt_d = (tx_cnt_q == LONG_BITS) ? tx_cnt_q : tx_cnt_q + 6'h01;
    if (tx_cnt_q == 6'h00) begin
      so_d = tx_result[23];
      tx_sh_d = {tx_result[22:0], 1'b0};
    end else if (tx_cnt_q == HALF_BITS) begin
      so_d = readback[23];
      tx_sh_d = {readback[22:0], 1'b0};
    end else begin
      so_d = tx_sh_q[23];
      tx_sh_d = {tx_sh_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_cnt_q <= 6'h00;
      tx_sh_q <= 24'h000000;
      so_q <= 1'b1;
      started_q <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      tx_sh_q <= tx_sh_d;
      so_q <= so_d;
      started_q <= 1'b1;
    end
  end

  // Falling edges sample input; only the first word of a frame counts
  always_comb begin
    rx_cnt_d = (rx_cnt_q == LONG_BITS) ? rx_cnt_q : rx_cnt_q + 6'h01;
    rx_sh_d = {rx_sh_q[21:0], sdi};
    rx_word_d = rx_word_q;
    rx_tgl_d = rx_tgl_q;
    if (rx_cnt_q == HALF_BITS - 6'h01) begin
      rx_word_d = {rx_sh_q, sdi};
      rx_tgl_d = ~rx_tgl_q;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rx_cnt_q <= 6'h00;
      rx_sh_q <= 23'h000000;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
    end
  end

  // Word and toggle outlive the frame so the other domain can take them
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      rx_word_q <= 24'h000000;
      rx_tgl_q <= 1'b0;
    end else begin
      rx_word_q <= rx_word_d;
      rx_tgl_q <= rx_tgl_d;
    end
  end

  assign started = started_q;
  assign so_bit = so_q;
  assign rx_word = rx_word_q;
  assign rx_toggle = rx_tgl_q;

endmodule // serial_link

// File: design/sync2.sv
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages; the first is read by the second only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sync2

// File: testbench/host_model.sv
// Host side of the serial link: frames data, makes the link clock
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock stands low outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end

  // One 48-bit frame; second half held high so it never writes
  task automatic xfer(input logic [23:0] w, output logic [47:0] r);
    logic [47:0] tx;
    tx = {w, 24'hffffff};
    r = '0;
    // Odd offset keeps link edges off the system clock edges
    #7.3 cs_n = 1'b0;
    #100;
    // Data changes after rise, sampled late in the low phase
    for (int i = 47; i >= 0; i--) begin
      sclk = 1'b1;
      #2 sdi = tx[i];
      #30 sclk = 1'b0;
      #30 r[i] = pin;
      #2;
    end
    #50 cs_n = 1'b1;
    #100;
  endtask
endmodule // host_model

// File: testbench/testbench.sv
module testbench;
  import adc_regs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, nrst, conv_done, conv_start, pullup_on, dout, oe;
  logic sclk, cs_n, sdi;
  logic [23:0] conv_data, val, w, exp_w;
  logic [15:0] conv_rate_sps, exp_r;
  logic [2:0] k;
  logic [1:0] b;
  logic [47:0] rd;
  cfg_s conv_cfg;
  int num_errors = 0;
  int check_count = 0;
  int starts = 0;
  int pend = 0;
  int s;

  // Released pin: pull-up level, else the inverse of the last level
  wire pin = oe ? dout : (pullup_on ? 1'b1 : ~dout);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  adc_config_result_regs u_dut (.clk_sys(clk_sys), .nrst(nrst),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .conv_done(conv_done),
    .conv_data(conv_data), .data_out_ready_n(dout),
    .data_out_ready_n_oe(oe), .pullup_on(pullup_on),
    .conv_start(conv_start), .conv_cfg(conv_cfg),
    .conv_rate_sps(conv_rate_sps));

  host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .pin(pin));

  // Converter stand-in; slow enough that a frame fits inside a conversion
  always @(posedge clk_sys) begin
    conv_done <= 1'b0;
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
      pend <= 1000;
    end else if (pend > 1) begin
      pend <= pend - 1;
    end else if (pend == 1) begin
      pend <= 0;
      conv_done <= 1'b1;
      conv_data <= val;
      val <= val + 24'h123457;
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Frame plus settling time for the written word
  task automatic wr(input logic [23:0] x);
    u_host.xfer(x, rd);
    clks(8);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #400000;
    num_errors++;
    $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
    results();
  end

  initial begin
    nrst = 1'b0;
    conv_done = 1'b0;
    conv_data = 24'h000000;
    val = 24'h800001;
    clks(6);
    nrst <= 1'b1;
    clks(4);
    chk(conv_cfg, CFG_RESET);
    chk(conv_rate_sps, 16'h0400);
    chk(pullup_on, 1'b1);
    chk(oe, 1'b0);
    chk(dout, 1'b1);
    $display("test reset done");
    // Held-high input and bad qualifiers leave the setting alone
    wr(24'hffffff);
    chk(rd, {24'h000000, CFG_RESET});
    for (int q = 0; q < 4; q += 2) begin
      b = q[1:0];
      wr({8'h7f, 3'h7, 2'h2, b, 9'h0c0});
      chk(conv_cfg, CFG_RESET);
    end
    $display("test qualifier done");
    // Every code of the input, gain, rate, boost, temp and chop fields, echo and stored view compared
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      b = k[1:0] ^ {2{k[2]}};
      w = {1'b0, k, k, 1'b1, k, k[0], 1'b1, 2'h1, ~k[0], b, k[1], 5'h1f};
      exp_w = (w & 24'h7ffee0) | 24'h000100;
      wr(w);
      chk(rd[23:0], exp_w);
      chk(conv_cfg, exp_w);
      exp_r = (b == 2'h0) ? (16'h0040 << k) :
              (b == 2'h1) ? 16'h3e80 : 16'h7d00;
      clks(1);
      chk(conv_rate_sps, exp_r);
    end
    $display("test fields done");
    wr(24'h058320);
    clks(4);
    chk(pullup_on, 1'b0);
    wr(CFG_RESET);
    clks(4);
    chk(pullup_on, 1'b1);
    $display("test pullup done");
    // Single shot: start, refused restart, readout, second start
    s = starts;
    wr(24'h858b20);
    chk(rd[23:0], CFG_RESET);
    chk(starts, s + 1);
    wr(24'h858b20);
    chk(starts, s + 1);
    clks(1000);
    chk(dout, 1'b0);
    wr(24'hffffff);
    chk(rd[47:24], 24'h800001);
    wr(24'h858b20);
    chk(starts, s + 2);
    clks(1000);
    wr(CFG_RESET);
    clks(20);
    chk(starts, s + 2);
    $display("test single done");
    // Continuous runs on its own until power-down is chosen again
    wr(24'h048b20);
    clks(3000);
    chk(starts >= s + 4, 1'b1);
    wr(CFG_RESET);
    clks(1100);
    s = starts;
    clks(2100);
    chk(starts, s);
    $display("test continuous done");
    results();
  end
endmodule // testbench
